// File: iwd_pkg.sv
// Package with field layout, opcode classes, timing counts and state types of the instruction word decoder
package iwd_pkg;

   // Instruction word layout
   localparam int WORD_W        = 24;
   localparam int OPC_HI        = 23;
   localparam int OPC_LO        = 16;
   localparam int BASE_HI       = 15;
   localparam int BASE_LO       = 12;
   localparam int DMODE_HI      = 11;
   localparam int DMODE_LO      = 10;
   localparam int DREG_HI       = 9;
   localparam int DREG_LO       = 6;
   localparam int SMODE_HI      = 5;
   localparam int SMODE_LO      = 4;
   localparam int SREG_HI       = 3;
   localparam int SREG_LO       = 0;
   localparam int BYTE_BIT      = 14;
   localparam int FDEST_BIT     = 13;
   localparam int FADDR_HI      = 12;
   localparam int FADDR_LO      = 0;
   localparam int BITIND_BIT    = 11;
   localparam int TEN_BIT_LITERAL_HI      = 13;
   localparam int TEN_BIT_LITERAL_LO      = 4;
   localparam int LIT5_HI       = 8;
   localparam int LIT5_LO       = 4;
   localparam int EXT_HI        = 15;
   localparam int EXT_LO        = 0;

   // Opcodes with a fixed meaning; others are grouped by range in the class table
   localparam logic [7:0] OP_NOP           = 8'h00;
   localparam logic [7:0] OP_BRANCH_ALWAYS = 8'h01;
   localparam logic [7:0] OP_CALL_IND      = 8'h02;
   localparam logic [7:0] OP_GOTO_IND      = 8'h03;
   localparam logic [7:0] OP_CALL_LONG     = 8'h04;
   localparam logic [7:0] OP_GOTO_LONG     = 8'h05;
   localparam logic [7:0] OP_MOVE_DOUBLE   = 8'h06;
   localparam logic [7:0] OP_RETURN        = 8'h07;
   localparam logic [7:0] OP_RETURN_INT    = 8'h08;
   localparam logic [7:0] OP_TABLE_FIRST   = 8'h0A;
   localparam logic [7:0] OP_TABLE_LAST    = 8'h0D;
   localparam logic [7:0] OP_COND_FIRST    = 8'h10;
   localparam logic [7:0] OP_COND_LAST     = 8'h1F;
   localparam logic [7:0] OP_SKIP_FIRST    = 8'h20;
   localparam logic [7:0] OP_SKIP_LAST     = 8'h27;
   localparam logic [7:0] OP_FILE_FIRST    = 8'h40;
   localparam logic [7:0] OP_FILE_LAST     = 8'h5F;
   localparam logic [7:0] OP_DEFAULT_WORKING_REG_FIRST    = 8'h60;
   localparam logic [7:0] OP_DEFAULT_WORKING_REG_LAST     = 8'h8F;
   localparam logic [7:0] OP_BIT_FIRST     = 8'h90;
   localparam logic [7:0] OP_BIT_LAST      = 8'hA7;
   localparam logic [7:0] OP_LIT_FIRST     = 8'hB0;
   localparam logic [7:0] OP_LIT_LAST      = 8'hBF;
   localparam logic [7:0] OP_LIT3_FIRST    = 8'hC0;
   localparam logic [7:0] OP_LIT3_LAST     = 8'hCF;

   // Instruction classes
   typedef enum logic [3:0] {
      CL_NOP    = 4'h0,
      CL_PLAIN  = 4'h1,
      CL_FILE   = 4'h2,
      CL_DEFAULT_WORKING_REG   = 4'h3,
      CL_BIT    = 4'h4,
      CL_LIT    = 4'h5,
      CL_LIT3   = 4'h6,
      CL_COND   = 4'h7,
      CL_JUMP2  = 4'h8,
      CL_JUMP3  = 4'h9,
      CL_SKIP   = 4'hA,
      CL_DOUBLE = 4'hB
   } iwd_class_type;

   // Added no-operation cycles per class
   localparam logic [1:0] EXTRA_COND   = 2'h1;
   localparam logic [1:0] EXTRA_JUMP2  = 2'h1;
   localparam logic [1:0] EXTRA_JUMP3  = 2'h2;
   localparam logic [1:0] EXTRA_DOUBLE = 2'h1;
   localparam logic [7:0] BYTE_LIT_MASK = 8'hFF;

   // Sequencer states
   typedef enum logic [7:0] {
      ST_FETCH   = 8'h01,
      ST_CLASS   = 8'h02,
      ST_FETCH2  = 8'h04,
      ST_ISSUE   = 8'h08,
      ST_EXTRA   = 8'h10,
      ST_SKIPF   = 8'h20,
      ST_SKIPCLS = 8'h40,
      ST_SKIP2   = 8'h80
   } iwd_state_type;

   // All state of the decoder
   typedef struct packed {
      iwd_state_type state;
      logic [23:0]   word;
      iwd_class_type cls;
      logic [1:0]    extra;
      logic          fetchReady;
      logic          execValid;
      logic          execNop;
      logic [7:0]    opcode;
      logic [3:0]    baseReg;
      logic [3:0]    srcReg;
      logic [1:0]    srcMode;
      logic [3:0]    dstReg;
      logic [1:0]    dstMode;
      logic [12:0]   fileAddr;
      logic          destIsFile;
      logic          byteMode;
      logic [3:0]    bitPos;
      logic          bitIndirect;
      logic [9:0]    literal;
      logic [15:0]   extWord;
      logic          secondWordError;
   } iwd_regs_type;

   localparam iwd_regs_type REGS_RESET = '{state: ST_FETCH, cls: CL_NOP, fetchReady: 1'b1, default: '0};

endpackage

// File: iwd_class_rom.sv
// Opcode to instruction class lookup with registered output
`timescale 1ns/1ns
module iwd_class_rom
   import iwd_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          resetn,
   input  wire logic [7:0]    opcode,
   output iwd_class_type      opClass
);

   iwd_class_type next_opClass;

   // Class by opcode
   always_comb begin
      next_opClass = CL_PLAIN;
      if (opcode == OP_NOP) begin
         next_opClass = CL_NOP;
      end else if (opcode == OP_BRANCH_ALWAYS || opcode == OP_CALL_IND || opcode == OP_GOTO_IND) begin
         next_opClass = CL_JUMP2;
      end else if (opcode == OP_CALL_LONG || opcode == OP_GOTO_LONG || opcode == OP_MOVE_DOUBLE) begin
         next_opClass = CL_DOUBLE;
      end else if (opcode == OP_RETURN || opcode == OP_RETURN_INT) begin
         next_opClass = CL_JUMP3;
      end else if (opcode >= OP_TABLE_FIRST && opcode <= OP_TABLE_LAST) begin
         next_opClass = CL_JUMP3;
      end else if (opcode >= OP_COND_FIRST && opcode <= OP_COND_LAST) begin
         next_opClass = CL_COND;
      end else if (opcode >= OP_SKIP_FIRST && opcode <= OP_SKIP_LAST) begin
         next_opClass = CL_SKIP;
      end else if (opcode >= OP_FILE_FIRST && opcode <= OP_FILE_LAST) begin
         next_opClass = CL_FILE;
      end else if (opcode >= OP_DEFAULT_WORKING_REG_FIRST && opcode <= OP_DEFAULT_WORKING_REG_LAST) begin
         next_opClass = CL_DEFAULT_WORKING_REG;
      end else if (opcode >= OP_BIT_FIRST && opcode <= OP_BIT_LAST) begin
         next_opClass = CL_BIT;
      end else if (opcode >= OP_LIT_FIRST && opcode <= OP_LIT_LAST) begin
         next_opClass = CL_LIT;
      end else if (opcode >= OP_LIT3_FIRST && opcode <= OP_LIT3_LAST) begin
         next_opClass = CL_LIT3;
      end
   end

   // Registered read
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         opClass <= CL_NOP;
      end else begin
         opClass <= next_opClass;
      end
   end

endmodule

// File: iwd_decoder.sv
// Instruction word decoder and cycle sequencer between program memory and datapath
// Notes on behaviour
// [RL1] A single word is 24 bits; top 8 bits are the opcode, rest operands.
// [RL2] Exactly three opcodes are double-word; both words are fetched before issue.
// [RL3] Second word has a zero top byte; its low 16 bits are extra operand.
// [RL4] A second word reached alone decodes as opcode zero and executes as no-operation.
// [RL5] Single word takes one cycle; two when its condition is true, extra one a no-op.
// [RL6] Branch, indirect jumps and calls, table access and returns take two or three cycles.
// [RL7] A taken skip costs two cycles over a single word, three over a double word.
// [RL8] Double-word instructions take two instruction cycles.
// [RL9] File instructions decode a file address and a file or default register destination.
// [RL10] Register instructions decode base, source with mode and destination with mode.
// [RL11] Bit instructions decode a target and a bit from literal or base register.
// [RL12] Literal arithmetic combines base and literal; separate destination only in the three-field form.
// [RL13] Ten-bit literal is limited to a byte in byte mode, full range in word mode.
// [RL14] Register fields select one of sixteen working registers.
`timescale 1ns/1ns
module iwd_decoder
   import iwd_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          resetn,
   input  wire logic [23:0]   fetchWord,
   input  wire logic          fetchValid,
   output logic               fetchReady,
   input  wire logic          condTrue,
   output logic               execValid,
   output logic               execNop,
   output iwd_class_type      execClass,
   output logic [7:0]         execOpcode,
   output logic [3:0]         execBaseReg,
   output logic [3:0]         execSrcReg,
   output logic [1:0]         execSrcMode,
   output logic [3:0]         execDstReg,
   output logic [1:0]         execDstMode,
   output logic [12:0]        execFileAddr,
   output logic               execDestIsFile,
   output logic               execByteMode,
   output logic [3:0]         execBitPos,
   output logic               execBitIndirect,
   output logic [9:0]         execLiteral,
   output logic [15:0]        execExtWord,
   output logic               execSecondWordError
);

   iwd_regs_type  q;
   iwd_regs_type  next_q;
   iwd_class_type romClass;
   logic [1:0]    nopCount;
   logic          skipTaken;
   logic [23:0]   w;

   // Class lookup of the word on the fetch port
   iwd_class_rom classRom (
      .clock   (clock),
      .resetn  (resetn),
      .opcode  (fetchWord[OPC_HI:OPC_LO]),
      .opClass (romClass)
   );

   // Next state and decoded fields
   always_comb begin
      next_q = q;
      next_q.execValid = 1'b0;
      next_q.execNop = 1'b0;
      nopCount = 2'h0;
      skipTaken = 1'b0;
      w = q.word;
      unique case (q.state)
         ST_FETCH: begin
            if (fetchValid) begin
               next_q.word = fetchWord;
               next_q.state = ST_CLASS;
            end
         end
         ST_CLASS: begin
            next_q.cls = romClass;
            next_q.opcode = w[OPC_HI:OPC_LO]; // RL1
            next_q.baseReg = w[BASE_HI:BASE_LO]; // RL14
            next_q.dstMode = w[DMODE_HI:DMODE_LO];
            next_q.dstReg = w[DREG_HI:DREG_LO];
            next_q.srcMode = w[SMODE_HI:SMODE_LO];
            next_q.srcReg = w[SREG_HI:SREG_LO];
            next_q.fileAddr = w[FADDR_HI:FADDR_LO];
            next_q.destIsFile = w[FDEST_BIT];
            next_q.byteMode = w[BYTE_BIT];
            next_q.bitPos = w[BASE_HI:BASE_LO];
            next_q.bitIndirect = 1'b0;
            next_q.literal = 10'h000;
            next_q.extWord = 16'h0000;
            next_q.secondWordError = 1'b0;
            unique case (romClass)
               CL_FILE: begin
                  // File address plus file or default register destination
                  next_q.byteMode = w[BYTE_BIT]; // RL9
               end
               CL_DEFAULT_WORKING_REG: begin
                  next_q.fileAddr = 13'h0000; // RL10
               end
               CL_BIT: begin
                  // Bit number from literal or from the base register
                  next_q.bitIndirect = w[BITIND_BIT]; // RL11
                  next_q.bitPos = w[BITIND_BIT] ? 4'h0 : w[BASE_HI:BASE_LO]; // RL11
               end
               CL_LIT: begin
                  // Destination is the base register itself
                  next_q.baseReg = w[SREG_HI:SREG_LO]; // RL12
                  next_q.dstReg = w[SREG_HI:SREG_LO]; // RL12
                  next_q.dstMode = 2'h0;
                  next_q.literal = w[BYTE_BIT] ? (w[TEN_BIT_LITERAL_HI:TEN_BIT_LITERAL_LO] & {2'h0, BYTE_LIT_MASK})
                                               : w[TEN_BIT_LITERAL_HI:TEN_BIT_LITERAL_LO]; // RL13
               end
               CL_LIT3: begin
                  next_q.literal = {5'h00, w[LIT5_HI:LIT5_LO]}; // RL12
               end
               default: begin
               end
            endcase
            if (romClass == CL_DOUBLE) begin
               next_q.state = ST_FETCH2; // RL2
            end else begin
               next_q.execValid = 1'b1;
               next_q.execNop = (romClass == CL_NOP); // RL4
               next_q.state = ST_ISSUE;
            end
         end
         ST_FETCH2: begin
            // Issue only once the second word is in
            if (fetchValid) begin
               next_q.extWord = fetchWord[EXT_HI:EXT_LO]; // RL3
               next_q.secondWordError = |fetchWord[OPC_HI:OPC_LO]; // RL3
               next_q.execValid = 1'b1; // RL2
               next_q.state = ST_ISSUE;
            end
         end
         ST_ISSUE: begin
            // Cycle count from class and condition
            unique case (q.cls)
               CL_COND:   nopCount = condTrue ? EXTRA_COND : 2'h0; // RL5
               CL_JUMP2:  nopCount = EXTRA_JUMP2; // RL6
               CL_JUMP3:  nopCount = EXTRA_JUMP3; // RL6
               CL_DOUBLE: nopCount = EXTRA_DOUBLE; // RL8
               CL_SKIP:   skipTaken = condTrue; // RL7
               default:   nopCount = 2'h0; // RL5
            endcase
            if (skipTaken) begin
               next_q.state = ST_SKIPF;
            end else if (nopCount != 2'h0) begin
               next_q.extra = nopCount;
               next_q.execValid = 1'b1;
               next_q.execNop = 1'b1; // RL5
               next_q.state = ST_EXTRA;
            end else begin
               next_q.state = ST_FETCH;
            end
         end
         ST_EXTRA: begin
            next_q.extra = q.extra - 2'h1;
            if (q.extra == 2'h1) begin
               next_q.state = ST_FETCH;
            end else begin
               next_q.execValid = 1'b1;
               next_q.execNop = 1'b1; // RL6
            end
         end
         ST_SKIPF: begin
            // Skipped word is consumed as a no-operation cycle
            if (fetchValid) begin
               next_q.execValid = 1'b1;
               next_q.execNop = 1'b1; // RL7
               next_q.state = ST_SKIPCLS;
            end
         end
         ST_SKIPCLS: begin
            next_q.state = (romClass == CL_DOUBLE) ? ST_SKIP2 : ST_FETCH; // RL7
         end
         ST_SKIP2: begin
            // Hold off fetch for the cycle of this last no-operation pulse
            if (fetchValid) begin
               next_q.execValid = 1'b1;
               next_q.execNop = 1'b1; // RL7
               next_q.extra = 2'h1;
               next_q.state = ST_EXTRA;
            end
         end
         default: begin
            next_q.state = ST_FETCH;
         end
      endcase
      next_q.fetchReady = (next_q.state == ST_FETCH) || (next_q.state == ST_FETCH2)
                          || (next_q.state == ST_SKIPF) || (next_q.state == ST_SKIP2);
   end

   // State register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q <= REGS_RESET;
      end else begin
         q <= next_q;
      end
   end

   // Outputs straight from the state register
   assign fetchReady          = q.fetchReady;
   assign execValid           = q.execValid;
   assign execNop             = q.execNop;
   assign execClass           = q.cls;
   assign execOpcode          = q.opcode;
   assign execBaseReg         = q.baseReg;
   assign execSrcReg          = q.srcReg;
   assign execSrcMode         = q.srcMode;
   assign execDstReg          = q.dstReg;
   assign execDstMode         = q.dstMode;
   assign execFileAddr        = q.fileAddr;
   assign execDestIsFile      = q.destIsFile;
   assign execByteMode        = q.byteMode;
   assign execBitPos          = q.bitPos;
   assign execBitIndirect     = q.bitIndirect;
   assign execLiteral         = q.literal;
   assign execExtWord         = q.extWord;
   assign execSecondWordError = q.secondWordError;

endmodule

// File: iwd_mem_model.sv
// Program memory model that offers queued words to the decoder
`timescale 1ns/1ns
module iwd_mem_model
   import iwd_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          fetchReady,
   output logic               fetchValid,
   output logic [23:0]        fetchWord
);
   logic [23:0] q [$];

   function automatic int level();
      return q.size();
   endfunction

   task automatic push(input logic [23:0] w);
      q.push_back(w);
   endtask

   // Drop taken word, offer next; idle data toggles so it is never mistaken for held
   initial begin
      fetchValid = 1'b0;
      fetchWord = 24'h000000;
   end
   always @(posedge clock) begin
      if (fetchValid && fetchReady) void'(q.pop_front());
      #1;
      fetchValid = (q.size() > 0);
      fetchWord = (q.size() > 0) ? q[0] : ~fetchWord;
   end
endmodule

// File: iwd_decoder_chk.sv
// Port timing checker for the decoder
`timescale 1ns/1ns
module iwd_decoder_chk
   import iwd_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          resetn,
   input  wire logic          fetchValid,
   input  wire logic          fetchReady,
   input  wire logic          condTrue,
   input  wire logic          execValid,
   input  wire logic          execNop,
   input  iwd_class_type      execClass,
   input  wire logic [7:0]    execOpcode,
   input  wire logic          execByteMode,
   input  wire logic [9:0]    execLiteral
);
   logic iss;

   // Real instruction issue
   assign iss = execValid && !execNop;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   a_take_answer: assert property (fetchValid && fetchReady |->
      (##[1:2] execValid) or (##2 (fetchReady && !execValid)))
      else $error("fetched word got no answer");
   a_issue_busy: assert property (execValid |-> !fetchReady)
      else $error("fetch ready during issue");
   a_single_issue: assert property (iss |=> !iss)
      else $error("back to back issue");
   a_field_hold: assert property ($changed(execOpcode) |-> execValid || execClass == CL_DOUBLE)
      else $error("opcode changed without issue");
   a_one_cycle: assert property (iss && (execClass == CL_PLAIN || execClass == CL_COND && !condTrue) |=> !execValid)
      else $error("single cycle instruction took more");
   a_cond_taken: assert property (iss && execClass == CL_COND && condTrue |=> execNop ##1 !execValid)
      else $error("taken condition lacks one nop");
   a_jump_two: assert property (iss && execClass == CL_JUMP2 |=> execNop ##1 !execValid)
      else $error("branch not two cycles");
   a_jump_three: assert property (iss && execClass == CL_JUMP3 |=> execNop [*2] ##1 !execValid)
      else $error("return or table not three cycles");
   a_double_two: assert property (iss && execClass == CL_DOUBLE |=> execNop ##1 !execValid)
      else $error("double word not two cycles");
   a_skip_fetch: assert property (iss && execClass == CL_SKIP && condTrue |=> fetchReady && !execValid)
      else $error("taken skip did not fetch skipped word");
   a_byte_lit: assert property (iss && execByteMode && execClass == CL_LIT |-> execLiteral[9:8] == 2'h0)
      else $error("byte literal above a byte");

   // Main scenarios reached
   c_jump3: cover property (iss && execClass == CL_JUMP3);
   c_skip: cover property (iss && execClass == CL_SKIP && condTrue);
   c_double: cover property (iss && execClass == CL_DOUBLE);
endmodule

bind iwd_decoder iwd_decoder_chk u_iwd_decoder_chk (.clock(clock), .resetn(resetn), .fetchValid(fetchValid),
   .fetchReady(fetchReady), .condTrue(condTrue), .execValid(execValid), .execNop(execNop),
   .execClass(execClass), .execOpcode(execOpcode), .execByteMode(execByteMode), .execLiteral(execLiteral));

// File: tb_instruction_word_decoder.sv
// Testbench for the instruction word decoder
`timescale 1ns/1ns
module tb_instruction_word_decoder;
   import iwd_pkg::*;
   logic          clock, resetn, fetchValid, fetchReady, condTrue, execValid, execNop;
   logic          execDestIsFile, execByteMode, execBitIndirect, execSecondWordError;
   logic [23:0]   fetchWord;
   iwd_class_type execClass;
   logic [7:0]    execOpcode;
   logic [3:0]    execBaseReg, execSrcReg, execDstReg, execBitPos;
   logic [1:0]    execSrcMode, execDstMode;
   logic [12:0]   execFileAddr;
   logic [9:0]    execLiteral;
   logic [15:0]   execExtWord;
   int            bad_count, comparisons, iss, nop;

   iwd_decoder u_iwd_decoder (.clock, .resetn, .fetchWord, .fetchValid, .fetchReady, .condTrue, .execValid,
      .execNop, .execClass, .execOpcode, .execBaseReg, .execSrcReg, .execSrcMode, .execDstReg, .execDstMode,
      .execFileAddr, .execDestIsFile, .execByteMode, .execBitPos, .execBitIndirect, .execLiteral,
      .execExtWord, .execSecondWordError);
   iwd_mem_model u_iwd_mem_model (.clock, .fetchReady, .fetchValid, .fetchWord);

   // Clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   // Count issue and nop pulses until memory drained and decoder idle
   task automatic run(input logic c);
      int k;
      @(posedge clock);
      #1 condTrue = c;
      iss = 0;
      nop = 0;
      for (k = 0; k < 40; k++) begin
         @(negedge clock);
         if (execValid === 1'b1 && execNop === 1'b1) nop++;
         if (execValid === 1'b1 && execNop === 1'b0) iss++;
         if (u_iwd_mem_model.level() == 0 && fetchReady === 1'b1 && k > 1) break;
      end
   endtask

   task automatic op(input logic [23:0] w, input logic c, input int eIss, input int eNop);
      u_iwd_mem_model.push(w);
      run(c);
      chk("issue count", eIss, iss);
      chk("nop count", eNop, nop);
   endtask

   task automatic sc_fields;
      op(24'h407FFF, 1'b0, 1, 0);
      chk("class", CL_FILE, execClass);
      chk("file addr", 13'h1FFF, execFileAddr);
      chk("dest file", 1'b1, execDestIsFile);
      op(24'h5F0000, 1'b1, 1, 0);
      chk("dest file", 1'b0, execDestIsFile);
      chk("opcode", 8'h5F, execOpcode);
      op(24'h60FE95, 1'b0, 1, 0);
      chk("base", 4'hF, execBaseReg);
      chk("dst mode", 2'h3, execDstMode);
      chk("dst", 4'hA, execDstReg);
      chk("src mode", 2'h1, execSrcMode);
      chk("src", 4'h5, execSrcReg);
      op(24'h903800, 1'b0, 1, 0);
      chk("class", CL_BIT, execClass);
      chk("bit indirect", 1'b1, execBitIndirect);
      op(24'hA75000, 1'b0, 1, 0);
      chk("bit indirect", 1'b0, execBitIndirect);
      chk("bit pos", 4'h5, execBitPos);
   endtask

   task automatic sc_literal;
      op(24'hB03FF0, 1'b0, 1, 0);
      chk("word literal", 10'h3FF, execLiteral);
      chk("byte mode", 1'b0, execByteMode);
      op(24'hBF7FF0, 1'b0, 1, 0);
      chk("byte literal", 10'h0FF, execLiteral);
      chk("byte mode", 1'b1, execByteMode);
      op(24'hC00000, 1'b0, 1, 0);
      chk("class", CL_LIT3, execClass);
   endtask

   task automatic sc_cycles;
      logic [7:0] ops [10] = '{8'h01, 8'h02, 8'h03, 8'h07, 8'h08, 8'h0A, 8'h0D, 8'h30, 8'h10, 8'h1F};
      int nops [10] = '{1, 1, 1, 2, 2, 2, 2, 0, 1, 0};
      int i;
      for (i = 0; i < 10; i++) op({ops[i], 16'h0000}, i == 8, 1, nops[i]);
   endtask

   task automatic sc_double;
      int i;
      for (i = 0; i < 3; i++) begin
         u_iwd_mem_model.push({OP_CALL_LONG + 8'(i), 16'h1234});
         op({8'h00, 16'hA5C0 + 16'(i)}, 1'b0, 1, 1);
         chk("ext word", 16'hA5C0 + 16'(i), execExtWord);
         chk("second word flag", 1'b0, execSecondWordError);
         chk("class", CL_DOUBLE, execClass);
      end
      u_iwd_mem_model.push(24'h040000);
      op(24'h011234, 1'b0, 1, 1);
      chk("second word flag", 1'b1, execSecondWordError);
      u_iwd_mem_model.push(24'h00ABCD);
      run(1'b0);
      chk("lone pulses", 1, iss + nop);
      chk("lone class", CL_NOP, execClass);
   endtask

   task automatic sc_skip;
      u_iwd_mem_model.push(24'h200000);
      op(24'h41FFFF, 1'b1, 1, 1);
      chk("skipped opcode", 8'h20, execOpcode);
      u_iwd_mem_model.push(24'h270000);
      u_iwd_mem_model.push(24'h050000);
      op(24'h001234, 1'b1, 1, 2);
      chk("skipped opcode", 8'h27, execOpcode);
      u_iwd_mem_model.push(24'h200000);
      op(24'h41FFFF, 1'b0, 2, 0);
      chk("next opcode", 8'h41, execOpcode);
   endtask

   task automatic give_verdict;
      $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Reset then scenarios
   initial begin
      resetn = 1'b0;
      condTrue = 1'b0;
      bad_count = 0;
      comparisons = 0;
      repeat (5) @(posedge clock);
      #1 resetn = 1'b1;
      sc_fields;
      sc_literal;
      sc_cycles;
      sc_double;
      sc_skip;
      give_verdict;
   end

   // Watchdog
   initial begin
      #200000;
      bad_count++;
      give_verdict;
   end
endmodule
